// File: pstx_core.sv
// Purpose: transmit mode logic: 16-bit split, daisy chain addressing, error handling
// Assumes: sync_rise_instant is a one-cycle pulse on the sync rising edge
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
// Notes on behaviour
// - 16-bit mode clips and scales 26-bit filter output to one 16-bit word.
// - simultaneous sampling captures the newest sample at the sync rising edge.
// - synchronous sampling captures the newest sample at the first slot delay.
// - 16-bit mode sends upper ten bits, truncated, in the first slot.
// - 16-bit mode clamps to plus/minus 480, sends low ten bits in second slot.
// - 16-bit mode repeats identical initialization data in both slots.
// - colliding slot delays suppress every second-slot transmission.
// - chain mode initialization uses the fixed chain setup slot.
// - after phase 3 the chain device goes silent and awaits Set Address.
// - Set Address reply goes out in the chain setup slot.
// - after address reply, blank syncs, then stay silent until Run Mode.
// - Run Mode answered in assigned slot; then commands ignored, data sent.
// - chain run forces 10-bit, even parity, 125 kBaud, address-derived slot.
// - sync pull-down stays on during chain initialization and chain run.
// - Set Address: id zero, function code holds address; reply OK or Error.
// - Run Mode: broadcast id, function code zero; reply OK with zero word.
// - reply codes 0x1e1 good, 0x1e2 error; address zero-extended on left.
// - address 0 unprogrammed; 1-3 close switch, 4-6 open; slots cycle.
// - sensor id 7 is global broadcast, accepted by every sensor.
// - offset error sends defect messages only while it lasts.
// - self-test fail or cleared ident flag latches defect until reset.
// - undervoltage or temperature fault halts all transmissions while present.
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pstx_core
#(
  parameter int unsigned BLANK_CYCLES = pstx_pkg::CHAIN_BLANK_CYC
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               sync_rise_instant,
  input  wire logic [25:0]        filter_out,
  input  wire logic               init_active,
  input  wire logic [9:0]         init_word,
  input  wire logic               init_done,
  input  wire pstx_pkg::pstx_cmd_t   cmd_in,
  input  wire pstx_pkg::pstx_fault_t fault_in,
  output pstx_pkg::pstx_tx_t      tx_out,
  output logic                    bus_switch_close,
  output logic                    sync_pulldown_en
);
  import pstx_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic is_assignable(input logic [2:0] id);
    is_assignable = (id != ID_UNPROG) && (id != ID_GLOBAL);
  endfunction

  function automatic logic [9:0] chain_slot(input logic [2:0] id);
    logic [1:0] pos;
    pos = id[2] ? 2'(id[1:0] + 2'h1) : id[1:0];
    case (pos)
      2'h1:    chain_slot = CHAIN_SLOT_ONE;
      2'h2:    chain_slot = CHAIN_SLOT_TWO;
      2'h3:    chain_slot = CHAIN_SLOT_THREE;
      default: chain_slot = CHAIN_SLOT_ONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [7:0]  addr_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] slots_ff;
  logic        acc_ok;

  assign acc_ok    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= acc_ok && hwrite;
      rd_pend_ff <= acc_ok && !hwrite;
      addr_ff    <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff  <= CTRL_RESET;
      slots_ff <= SLOTS_RESET;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        REG_CTRL:  ctrl_ff  <= hwdata;
        REG_SLOTS: slots_ff <= hwdata;
        default:   ;
      endcase
    end
  end

  logic [1:0]  mode;
  logic        latency_sync;
  logic [9:0]  slot_a;
  logic [9:0]  slot_b;
  assign mode         = ctrl_ff[CTRL_MODE_LSB +: 2];
  assign latency_sync = ctrl_ff[CTRL_LAT_BIT];
  assign slot_a       = slots_ff[SLOTS_A_LSB +: 10];
  assign slot_b       = slots_ff[SLOTS_B_LSB +: 10];

  // ----------------------------------------------------------------
  // timebase: 0.5 us units from the sync rising edge
  // ----------------------------------------------------------------
  logic [9:0]  frac_ff;
  logic [9:0]  unit_ff;
  logic        run_ff;
  logic        unit_tick;
  logic [10:0] frac_sum;

  assign frac_sum  = {1'b0, frac_ff} + {1'b0, FRAC_STEP};
  assign unit_tick = run_ff && (frac_sum >= {1'b0, FRAC_WRAP});

  // fractional step keeps 12.5 cycles per unit on average
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frac_ff <= 10'h000;
      unit_ff <= 10'h000;
      run_ff  <= 1'b0;
    end else if (sync_rise_instant) begin
      frac_ff <= 10'h000;
      unit_ff <= 10'h000;
      run_ff  <= 1'b1;
    end else if (run_ff) begin
      frac_ff <= unit_tick ? 10'(frac_sum - {1'b0, FRAC_WRAP}) : frac_sum[9:0];
      if (unit_tick) begin
        unit_ff <= 10'(unit_ff + 10'h001);
        run_ff  <= (unit_ff != 10'h3ff);
      end
    end
  end

  logic        hit_a;
  logic        hit_b;
  logic        collide;
  assign hit_a   = unit_tick && (10'(unit_ff + 10'h001) == slot_a);
  assign hit_b   = unit_tick && (10'(unit_ff + 10'h001) == slot_b);
  // the two slots must start at least one frame apart, in either order
  assign collide = ({1'b0, slot_b} < ({1'b0, slot_a} + FRAME_UNITS)) && ({1'b0, slot_a} < ({1'b0, slot_b} + FRAME_UNITS));

  // ----------------------------------------------------------------
  // sample path and 16-bit scaling
  // ----------------------------------------------------------------
  logic [15:0] word16;
  logic        over_pos;
  logic        over_neg;
  logic [16:0] rounded;
  logic [25:0] sample_ff;

  assign over_pos = !filter_out[25] && (filter_out[24:21] != 4'h0);
  assign over_neg =  filter_out[25] && (filter_out[24:21] != 4'hf);
  assign rounded  = {filter_out[21], filter_out[21:6]} + {16'h0000, filter_out[5]};

  // clip outside the 16-bit window, round the dropped bits
  assign word16 = (over_pos || (!filter_out[21] && rounded[15])) ? 16'h7fff :
                  over_neg ? 16'h8000 : rounded[15:0];

  logic [15:0] held16_ff;
  logic [15:0] word_a;
  logic signed [15:0] sw;
  logic [9:0]  low10;

  assign word_a = latency_sync ? word16 : held16_ff;
  assign sw     = signed'(held16_ff);
  assign low10  = (sw > CLAMP_POS) ? CLAMP_POS[9:0] :
                  (sw < CLAMP_NEG) ? CLAMP_NEG[9:0] : held16_ff[9:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held16_ff <= 16'h0000;
      sample_ff <= 26'h0000000;
    end else if (sync_rise_instant && !latency_sync) begin
      held16_ff <= word16;
      sample_ff <= filter_out;
    end else if (hit_a && latency_sync) begin
      held16_ff <= word16;
      sample_ff <= filter_out;
    end
  end

  logic [9:0]  data10;
  assign data10 = latency_sync ? filter_out[21:12] : sample_ff[21:12];

  // ----------------------------------------------------------------
  // fault handling
  // ----------------------------------------------------------------
  logic defect_latch_ff;
  logic halted;
  logic defect;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      defect_latch_ff <= 1'b0;
    end else if (fault_in.selftest_fail || !fault_in.ident_valid_flag_a || !fault_in.ident_valid_flag_b) begin
      defect_latch_ff <= 1'b1;
    end
  end

  assign defect = defect_latch_ff || fault_in.offset_err;
  assign halted = fault_in.undervolt || fault_in.temp_range;

  // ----------------------------------------------------------------
  // daisy chain sequencer
  // ----------------------------------------------------------------
  pstx_chain_t state_ff;
  pstx_chain_t nxt_state;
  logic [2:0]  addr_id_ff;
  logic [1:0]  reply_left_ff;
  logic [9:0]  reply_code_ff;
  logic [9:0]  reply_data_ff;
  logic        reply_run_ff;
  logic        reply_ok_ff;
  logic [14:0] blank_ff;
  logic        chain;
  logic        reply_hit;
  logic        set_cmd;
  logic        run_cmd;
  logic        cmd_take;

  assign chain    = (mode == MODE_CHAIN);
  assign set_cmd  = (cmd_in.sensor_bus_id == ID_UNPROG);
  assign run_cmd  = (cmd_in.sensor_bus_id == ID_GLOBAL) && (cmd_in.function_code == FC_RUN);
  assign cmd_take = cmd_in.valid && (reply_left_ff == 2'h0) &&
                    (((state_ff == CH_WAIT_ADDR) && set_cmd) || ((state_ff == CH_WAIT_RUN) && run_cmd));
  assign reply_hit = unit_tick && (10'(unit_ff + 10'h001) ==
                     (reply_run_ff ? chain_slot(addr_id_ff) : CHAIN_SETUP_SLOT));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CH_OFF:       if (chain) nxt_state = CH_INIT;
      CH_INIT:      if (init_done) nxt_state = CH_WAIT_ADDR;
      CH_WAIT_ADDR: if (reply_hit && reply_left_ff == 2'h1 && reply_ok_ff) nxt_state = CH_BLANK;
      CH_BLANK:     if (blank_ff == 15'h0000) nxt_state = CH_WAIT_RUN;
      CH_WAIT_RUN:  if (reply_hit && reply_left_ff == 2'h1 && reply_ok_ff) nxt_state = CH_RUN;
      CH_RUN:       nxt_state = CH_RUN;
      default:      nxt_state = CH_OFF;
    endcase
    if (!chain) begin
      nxt_state = CH_OFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= CH_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_ff <= 15'h0000;
    end else if (state_ff != CH_BLANK) begin
      blank_ff <= 15'(BLANK_CYCLES - 1);
    end else if (blank_ff != 15'h0000) begin
      blank_ff <= 15'(blank_ff - 15'h0001);
    end
  end

  // two-word reply: code, then address / zero / error number
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reply_left_ff <= 2'h0;
      reply_code_ff <= 10'h000;
      reply_data_ff <= 10'h000;
      reply_run_ff  <= 1'b0;
      reply_ok_ff   <= 1'b0;
      addr_id_ff    <= ID_UNPROG;
    end else if (!chain) begin
      reply_left_ff <= 2'h0;
    end else if (cmd_take) begin
      reply_left_ff <= 2'h2;
      reply_run_ff  <= run_cmd;
      if (!cmd_in.crc_ok || (set_cmd && !is_assignable(cmd_in.function_code))) begin
        reply_code_ff <= REPLY_ERR;
        reply_data_ff <= ERRNUM_BAD;
        reply_ok_ff   <= 1'b0;
      end else if (set_cmd) begin
        reply_code_ff <= REPLY_OK;
        reply_data_ff <= {7'h00, cmd_in.function_code};
        reply_ok_ff   <= 1'b1;
        addr_id_ff    <= cmd_in.function_code;
      end else begin
        reply_code_ff <= REPLY_OK;
        reply_data_ff <= 10'h000;
        reply_ok_ff   <= 1'b1;
      end
    end else if (reply_hit && reply_left_ff != 2'h0 && !halted) begin
      reply_left_ff <= 2'(reply_left_ff - 2'h1);
      reply_code_ff <= reply_data_ff;
    end
  end

  assign bus_switch_close = chain && is_assignable(addr_id_ff) && !addr_id_ff[2];
  assign sync_pulldown_en = chain ? ((state_ff == CH_INIT) || (state_ff == CH_RUN)) : ctrl_ff[CTRL_PD_BIT];

  // ----------------------------------------------------------------
  // transmit request
  // ----------------------------------------------------------------
  pstx_tx_t nxt_tx;

  always_comb begin
    nxt_tx = '0;
    case (state_ff)
      CH_OFF: begin
        if (hit_a) begin
          nxt_tx.start = 1'b1;
          nxt_tx.word  = init_active ? init_word : defect ? DEFECT_WORD :
                         (mode == MODE_RES16) ? word_a[15:6] : data10;
        end else if (hit_b && !collide && (mode == MODE_RES16)) begin
          nxt_tx.start = 1'b1;
          nxt_tx.word  = init_active ? init_word : defect ? DEFECT_WORD : low10;
        end
      end
      CH_INIT: begin
        if (unit_tick && (10'(unit_ff + 10'h001) == CHAIN_SETUP_SLOT) && init_active) begin
          nxt_tx.start = 1'b1;
          nxt_tx.word  = init_word;
        end
      end
      CH_RUN: begin
        if (reply_left_ff != 2'h0) begin
          nxt_tx.start = reply_hit;
          nxt_tx.word  = reply_code_ff;
        end else if (unit_tick && (10'(unit_ff + 10'h001) == chain_slot(addr_id_ff))) begin
          nxt_tx.start = 1'b1;
          nxt_tx.word  = defect ? DEFECT_WORD : data10;
        end
        nxt_tx.force_fmt = 1'b1;
      end
      default: begin
        // waiting states: only command replies, sync pulses otherwise unanswered
        nxt_tx.start     = reply_hit && (reply_left_ff != 2'h0);
        nxt_tx.word      = reply_code_ff;
        nxt_tx.force_fmt = 1'b1;
      end
    endcase
    if (halted) begin
      nxt_tx.start = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_out <= '0;
    end else begin
      // word stands until the next start
      tx_out <= nxt_tx.start ? nxt_tx : pstx_tx_t'{1'b0, tx_out.word, nxt_tx.force_fmt};
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_ff) begin
      case (addr_ff)
        REG_CTRL:   hrdata = ctrl_ff;
        REG_SLOTS:  hrdata = slots_ff;
        REG_STATUS: hrdata = {20'h00000, collide, halted, defect, defect_latch_ff,
                              1'b0, addr_id_ff, 1'b0, state_ff};
        REG_TXWORD: hrdata = {22'h000000, tx_out.word};
        default:    hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: pstx_pkg.sv
// Purpose: shared constants and types of the sensor transmit mode block
// Assumes: 25 MHz hclk, slot times counted in 0.5 us units
// Notes:   register map, mode codes, chain slot defaults, carriers
package pstx_pkg;

  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SLOT_UNIT_NS   = 500;
  localparam logic [9:0]  FRAC_STEP      = 10'(CLK_PERIOD_NS);
  localparam logic [9:0]  FRAC_WRAP      = 10'(SLOT_UNIT_NS);
  localparam int unsigned CHAIN_BLANK_US = 500;
  localparam int unsigned CHAIN_BLANK_CYC = (CHAIN_BLANK_US * 1000) / CLK_PERIOD_NS;
  // one 13-bit frame at 125 kBaud is 104 us, i.e. 208 slot units
  localparam logic [10:0] FRAME_UNITS    = 11'h0d0;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SLOTS  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TXWORD = 8'h0c;

  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_LAT_BIT   = 4;
  localparam int unsigned CTRL_PD_BIT    = 5;
  localparam int unsigned SLOTS_A_LSB    = 0;
  localparam int unsigned SLOTS_B_LSB    = 16;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] SLOTS_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // modes, codes, chain slots (units of 0.5 us)
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_RES16  = 2'h2;
  localparam logic [1:0] MODE_CHAIN  = 2'h3;

  localparam logic [9:0] REPLY_OK      = 10'h1e1;
  localparam logic [9:0] REPLY_ERR     = 10'h1e2;
  localparam logic [9:0] ERRNUM_BAD    = 10'h001;
  localparam logic [9:0] DEFECT_WORD   = 10'h1fc;
  localparam logic [2:0] ID_UNPROG     = 3'h0;
  localparam logic [2:0] ID_GLOBAL     = 3'h7;
  localparam logic [2:0] FC_RUN        = 3'h0;
  localparam logic [9:0] CHAIN_SETUP_SLOT = 10'h00c;
  localparam logic [9:0] CHAIN_SLOT_ONE   = 10'h00c;
  localparam logic [9:0] CHAIN_SLOT_TWO   = 10'h0ec;
  localparam logic [9:0] CHAIN_SLOT_THREE = 10'h1cc;
  localparam logic signed [15:0] CLAMP_POS = 16'sh01e0;
  localparam logic signed [15:0] CLAMP_NEG = -16'sh01e0;

  typedef enum logic [2:0] {
    CH_OFF       = 3'b000,
    CH_INIT      = 3'b001,
    CH_WAIT_ADDR = 3'b010,
    CH_BLANK     = 3'b011,
    CH_WAIT_RUN  = 3'b100,
    CH_RUN       = 3'b101
  } pstx_chain_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] sensor_bus_id;
    logic [2:0] function_code;
    logic       crc_ok;
  } pstx_cmd_t;

  typedef struct packed {
    logic       start;
    logic [9:0] word;
    logic       force_fmt;
  } pstx_tx_t;

  typedef struct packed {
    logic offset_err;
    logic selftest_fail;
    logic ident_valid_flag_a;
    logic ident_valid_flag_b;
    logic undervolt;
    logic temp_range;
  } pstx_fault_t;

endpackage

// File: pstx_core_sva.sv
// Purpose: port-level checks of the sensor transmit mode block
// Assumes: single hclk domain, hresetn active low
// Notes:   bound into pstx_core from the bench
`timescale 1ns/10ps
`default_nettype none
module pstx_core_sva (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire pstx_pkg::pstx_fault_t fault_in,
  input wire pstx_pkg::pstx_tx_t    tx_out
);
  import pstx_pkg::*;
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic dphase_ff;
  logic fail_seen_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_ff <= 1'b0;
    end else begin
      dphase_ff <= hsel & hready & htrans[1];
    end
  end
  // sticky until reset, like the latched defect itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_seen_ff <= 1'b0;
    end else begin
      fail_seen_ff <= fail_seen_ff | fault_in.selftest_fail | ~fault_in.ident_valid_flag_a | ~fault_in.ident_valid_flag_b;
    end
  end
  sequence s_halted2;
    (fault_in.undervolt | fault_in.temp_range) ##1 (fault_in.undervolt | fault_in.temp_range);
  endsequence
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_idle: assert property (!dphase_ff |-> hrdata == 32'h0) else $error("hrdata outside data phase");
  a_start_gap: assert property (tx_out.start |=> !tx_out.start [*8]) else $error("start too close");
  a_word_hold: assert property (!tx_out.start |-> $stable(tx_out.word)) else $error("word moved");
  a_halt_silent: assert property (s_halted2 |-> !tx_out.start) else $error("start while halted");
  a_offset_defect: assert property (tx_out.start && fault_in.offset_err && $past(fault_in.offset_err)
    |-> tx_out.word == DEFECT_WORD) else $error("offset error without defect word");
  a_latch_defect: assert property (tx_out.start && $past(fail_seen_ff)
    |-> tx_out.word == DEFECT_WORD) else $error("latched defect not sent");
endmodule
`default_nettype wire

// File: pstx_rx_model.sv
// Purpose: receiver model: sync pulses, decoded commands, frame capture
// Assumes: tx_out.start is a one-cycle pulse
// Notes:   command fields show inverted values when not valid
`timescale 1ns/10ps
`default_nettype none
module pstx_rx_model #(
  parameter int WIN = 3100
) (
  input  wire logic               hclk,
  input  wire pstx_pkg::pstx_tx_t tx_out,
  output pstx_pkg::pstx_cmd_t     cmd_in,
  output logic                    sync_rise_instant
);
  import pstx_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and capture
  // ----------------------------------------------------------------
  initial begin
    sync_rise_instant = 1'b0;
    cmd_in = '0;
  end
  task automatic send_cmd(input logic [2:0] id, input logic [2:0] fc, input logic ok);
    @(posedge hclk);
    cmd_in <= '{1'b1, id, fc, ok};
    @(posedge hclk);
    cmd_in <= '{1'b0, ~id, ~fc, ~ok};
  endtask
  task automatic frame(output int n, output logic [9:0] w0, output logic [9:0] w1, output int t0, output logic fmt);
    n = 0;
    t0 = 0;
    @(posedge hclk);
    sync_rise_instant <= 1'b1;
    @(posedge hclk);
    sync_rise_instant <= 1'b0;
    for (int i = 1; i < WIN; i++) begin
      @(posedge hclk);
      if (tx_out.start === 1'b1) begin
        if (n == 0) begin
          t0 = i;
          w0 = tx_out.word;
          fmt = tx_out.force_fmt;
        end else begin
          w1 = tx_out.word;
        end
        n++;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench of the sensor transmit mode block
// Assumes: 25 MHz hclk, short chain blanking for simulation
// Notes:   registers over AHB-Lite, link traffic through the receiver model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pstx_pkg::*;
  // ----------------------------------------------------------------
  // signals, instances, helpers
  // ----------------------------------------------------------------
  localparam int          BLANK = 20;
  localparam logic [25:0] F_OLD = 26'h00048c0;
  localparam logic [25:0] F_NEW [4] = '{26'h0010000, 26'h0010000, 26'h3ff0000, 26'h1000000};
  localparam logic [3:0]  LAT = 4'b1110;
  localparam logic [9:0]  EA [4] = '{10'h004, 10'h010, 10'h3f0, 10'h1ff};
  localparam logic [9:0]  EB [4] = '{10'h123, 10'h1e0, 10'h220, 10'h1e0};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fmt;
  logic        init_active, init_done, sync_rise_instant, bus_switch_close, sync_pulldown_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [25:0] filter_out;
  logic [9:0]  init_word, w0, w1;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  pstx_cmd_t   cmd_in;
  pstx_fault_t fault_in;
  pstx_tx_t    tx_out;
  int          error_cnt = 0, check_count = 0, n, t0;
  pstx_core #(.BLANK_CYCLES(BLANK)) i_pstx_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sync_rise_instant, .filter_out, .init_active, .init_word,
    .init_done, .cmd_in, .fault_in, .tx_out, .bus_switch_close, .sync_pulldown_en);
  pstx_rx_model i_pstx_rx_model (.hclk, .tx_out, .cmd_in, .sync_rise_instant);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // slot timing drifts by the fractional unit accumulator
  task automatic chk_at(input int got, input int exp);
    check_count++;
    if (got < exp - 4 || got > exp + 4) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic expect_frame(input int en, input logic [9:0] e0, input logic [9:0] e1, input int slot);
    i_pstx_rx_model.frame(n, w0, w1, t0, fmt);
    chk(32'(n), 32'(en));
    if (en > 0) begin
      chk(32'(w0), 32'(e0));
      chk_at(t0, slot * 25 / 2);
    end
    if (en > 1) begin
      chk(32'(w1), 32'(e1));
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    ahb(1'b0, REG_SLOTS, 32'h0);
    chk(rd, SLOTS_RESET);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, REG_SLOTS, 32'h00f0_0014);
    ahb(1'b0, REG_SLOTS, 32'h0);
    chk(rd, 32'h00f0_0014);
  endtask
  task automatic t_res16;
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, REG_CTRL, {27'h0, LAT[i], 2'h0, MODE_RES16});
      filter_out <= F_OLD;
      fork
        expect_frame(2, EA[i], EB[i], 20);
        begin
          repeat (100) @(posedge hclk);
          filter_out <= F_NEW[i];
        end
      join
    end
  endtask
  task automatic t_slots;
    init_active <= 1'b1;
    init_word <= 10'h155;
    expect_frame(2, 10'h155, 10'h155, 20);
    init_active <= 1'b0;
    ahb(1'b1, REG_SLOTS, 32'h0064_0014);
    expect_frame(1, 10'h1ff, 10'h0, 20);
    ahb(1'b1, REG_SLOTS, 32'h00f0_0014);
    for (int k = 0; k < 2; k++) begin
      fault_in.undervolt <= (k == 0);
      fault_in.temp_range <= (k == 1);
      expect_frame(0, 10'h0, 10'h0, 0);
    end
    fault_in.temp_range <= 1'b0;
    expect_frame(2, 10'h1ff, 10'h1e0, 20);
  endtask
  task automatic t_chain;
    ahb(1'b1, REG_CTRL, {30'h0, MODE_CHAIN});
    init_active <= 1'b1;
    init_word <= 10'h2aa;
    expect_frame(1, 10'h2aa, 10'h0, 12);
    chk(32'(sync_pulldown_en), 32'h1);
    init_active <= 1'b0;
    init_done <= 1'b1;
    @(posedge hclk);
    init_done <= 1'b0;
    expect_frame(0, 10'h0, 10'h0, 0);
    i_pstx_rx_model.send_cmd(3'h0, 3'h7, 1'b1);
    expect_frame(1, REPLY_ERR, 10'h0, 12);
    expect_frame(1, ERRNUM_BAD, 10'h0, 12);
    i_pstx_rx_model.send_cmd(3'h0, 3'h2, 1'b1);
    expect_frame(1, REPLY_OK, 10'h0, 12);
    expect_frame(1, 10'h002, 10'h0, 12);
    chk(32'(bus_switch_close), 32'h1);
    expect_frame(0, 10'h0, 10'h0, 0);
    i_pstx_rx_model.send_cmd(3'h7, 3'h0, 1'b1);
    expect_frame(1, REPLY_OK, 10'h0, 236);
    expect_frame(1, 10'h000, 10'h0, 236);
    i_pstx_rx_model.send_cmd(3'h0, 3'h5, 1'b1);
    i_pstx_rx_model.frame(n, w0, w1, t0, fmt);
    chk(32'(n), 32'h1);
    chk_at(t0, 2950);
    chk(32'(fmt), 32'h1);
    chk(32'(bus_switch_close), 32'h1);
    chk(32'(sync_pulldown_en), 32'h1);
  endtask
  task automatic t_defect;
    for (int k = 0; k < 2; k++) begin
      do_reset;
      ahb(1'b1, REG_SLOTS, 32'h0000_0014);
      fault_in.offset_err <= 1'b1;
      expect_frame(1, DEFECT_WORD, 10'h0, 20);
      fault_in.offset_err <= 1'b0;
      i_pstx_rx_model.frame(n, w0, w1, t0, fmt);
      chk({31'h0, w0 !== DEFECT_WORD}, 32'h1);
      if (k == 0) begin
        fault_in.selftest_fail <= 1'b1;
      end else begin
        fault_in.ident_valid_flag_b <= 1'b0;
      end
      @(posedge hclk);
      fault_in.selftest_fail <= 1'b0;
      fault_in.ident_valid_flag_b <= 1'b1;
      expect_frame(1, DEFECT_WORD, 10'h0, 20);
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (99000) @(posedge hclk);
    error_cnt++;
    summarize;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    filter_out = 26'h0;
    init_active = 1'b0;
    init_word = 10'h0;
    init_done = 1'b0;
    fault_in = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    @(posedge hclk);
    do_reset;
    t_regs;
    t_res16;
    t_slots;
    t_chain;
    t_defect;
    summarize;
  end
endmodule
bind pstx_core pstx_core_sva i_pstx_core_sva (.hclk, .hresetn, .hsel, .htrans, .hready, .hrdata, .hreadyout,
  .hresp, .fault_in, .tx_out);
`default_nettype wire
